// ---- nbi_pkg.sv ----
// Shared constants for the NAND bus host controller
package nbi_pkg;
  localparam int DATA_W      = 8;
  localparam int COL_W       = 12;
  localparam int ROW_W       = 18;
  localparam int ADDR_CYCLES = 5;
  localparam int PAGE_BYTES  = 2112;
  localparam int MAIN_BYTES  = 2048;
  localparam int SPARE_BYTES = 64;
  localparam int PAGES_PER_BLK = 64;
  localparam int NUM_BLOCKS  = 4096;
  localparam int PLANE_BIT   = 6;
  localparam int PAGE_BITS   = 6;
  localparam int FIFO_DEPTH  = 16;
  // Strobe timing, in ns, and derived cycle counts at 100 MHz
  localparam int CLK_PERIOD_NS = 10;
  localparam int STROBE_LOW_NS = 20;
  localparam int STROBE_HIGH_NS = 20;
  localparam int LOW_CYC  = (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HIGH_CYC = (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] TIM_LOW  = 4'(LOW_CYC);
  localparam logic [3:0] TIM_HIGH = 4'(HIGH_CYC);
  // Request kinds
  localparam logic [1:0] OP_CMD  = 2'h0;
  localparam logic [1:0] OP_ADDR = 2'h1;
  localparam logic [1:0] OP_DIN  = 2'h2;
  localparam logic [1:0] OP_DOUT = 2'h3;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [2:0] CYC_ZERO = 3'h0;
  localparam logic [2:0] CYC_LAST = 3'h4;
  localparam logic [COL_W-1:0] COL_ONE = 12'h001;
endpackage : nbi_pkg

// ---- nbi_fifo.sv ----
// Parameterised valid/ready FIFO in flip-flops
`timescale 1ns/1ps
module nbi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // nbi_fifo

// ---- nbi_host.sv ----
// Host controller driving the multiplexed NAND flash bus
// Behaviour
// R1: Chip enable high deselects; device tristates.
// R2: Host drives chip enable low to select.
// R3: Bytes latch on write enable rising edge.
// R4: Command latch high marks command byte.
// R5: Address latch high marks address byte.
// R6: Read enable pulses; sample after falling edge.
// R7: Device steps column per read pulse.
// R8: Write protect low blocks program/erase.
// R9: Busy low during operations, high after.
// R10: Host supplies pull-up on ready/busy.
// R11: One shared 8-bit bus, strobes select kind.
// R12: Five address cycles; 12-bit column first.
// R13: 18-bit row in cycles three to five.
// R14: Host drives unused address bits low.
// R15: Row bit A18 selects plane.
// R16: Extra address bytes ignored by device.
// R17: Array holds 4096 blocks.
// R18: Each block holds 64 pages.
// R19: Page has 2048 main, 64 spare bytes.
// R20: Latch enable pattern selects command/address.
// R21: Row splits into page and block.
// R22: At most one latch enable per cycle.
`timescale 1ns/1ps
module nbi_host #(
  parameter int DATA_W = nbi_pkg::DATA_W,
  parameter int DEPTH  = nbi_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // Request port
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic [1:0]        req_op,
  input  wire logic [DATA_W-1:0] req_byte,
  input  wire logic              req_last,
  // Full address load
  input  wire logic              addr_valid,
  input  wire logic [nbi_pkg::COL_W-1:0] addr_col,
  input  wire logic [nbi_pkg::ROW_W-1:0] addr_row,
  // Read data out
  output logic                   rd_valid,
  input  wire logic              rd_ready,
  output logic [DATA_W-1:0]      rd_data,
  // Status
  output logic                   busy,
  output logic                   idle,
  output logic                   dev_ready,
  output logic [nbi_pkg::COL_W-1:0] col_track,
  output logic                   plane_sel,
  output logic [5:0]             page_sel,
  output logic [11:0]            block_sel,
  input  wire logic              wp_enable,
  // Flash pins
  output logic                   ce_n,
  output logic                   cle,
  output logic                   ale,
  output logic                   we_n,
  output logic                   re_n,
  output logic                   wp_n,
  input  wire logic              rb_in,
  input  wire logic [DATA_W-1:0] io_in,
  output logic [DATA_W-1:0]      io_out,
  output logic                   io_oe_n
);
  typedef enum logic [2:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_ADDR_LOW, ST_ADDR_HIGH}
    nbi_state_type;

  nbi_state_type    st_r, st_nxt;
  logic [3:0]       tim_r;
  logic [1:0]       op_r;
  logic             last_r;
  logic [2:0]       acyc_r;
  logic [39:0]      abuf_r;
  logic             ce_n_r, cle_r, ale_r, we_n_r, re_n_r, oe_n_r;
  logic [DATA_W-1:0] io_r;
  logic             rb_s_r;
  logic [nbi_pkg::COL_W-1:0] col_r;
  logic [nbi_pkg::ROW_W-1:0] row_r;
  logic             push_v;
  logic             fifo_in_ready;

  // Five address bytes, unused high bits forced low
  wire [39:0] abytes = {6'h00, addr_row[17:16], addr_row[15:8], addr_row[7:0],
                        4'h0, addr_col[11:8], addr_col[7:0]}; // R12 R13 R14
  wire        tim_done  = (tim_r == 4'h0);
  wire        is_read   = (op_r == nbi_pkg::OP_DOUT);
  // Address load wins over a plain request
  wire        take_req  = (st_r == ST_IDLE) && req_valid && !addr_valid;
  wire        take_addr = (st_r == ST_IDLE) && addr_valid;
  wire        rd_room   = !is_read || fifo_in_ready;
  // Exactly the cycles the device needs, no more
  wire        cyc_done  = (acyc_r == nbi_pkg::CYC_LAST); // R12 R16

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (take_addr) begin
          st_nxt = ST_ADDR_LOW;
        end else if (take_req) begin
          st_nxt = ST_LOW;
        end
      end
      ST_LOW: begin
        if (tim_done && rd_room) begin
          st_nxt = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (tim_done) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_ADDR_LOW: begin
        if (tim_done) begin
          st_nxt = ST_ADDR_HIGH;
        end
      end
      ST_ADDR_HIGH: begin
        if (tim_done) begin
          st_nxt = cyc_done ? ST_IDLE : ST_ADDR_LOW;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  // Sample read byte at end of strobe low phase
  assign push_v = (st_r == ST_LOW) && is_read && tim_done && fifo_in_ready; // R6

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r   <= ST_IDLE;
      tim_r  <= 4'h0;
    end else begin
      st_r <= st_nxt;
      if (st_nxt != st_r) begin
        tim_r <= (st_nxt == ST_LOW || st_nxt == ST_ADDR_LOW) ? nbi_pkg::TIM_LOW - 4'h1
                                                             : nbi_pkg::TIM_HIGH - 4'h1;
      end else if (!tim_done) begin
        tim_r <= tim_r - 4'h1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      op_r   <= nbi_pkg::OP_CMD;
      last_r <= 1'b1;
      io_r   <= nbi_pkg::BYTE_ZERO;
      acyc_r <= nbi_pkg::CYC_ZERO;
      abuf_r <= '0;
    end else if (take_addr) begin
      op_r   <= nbi_pkg::OP_ADDR;
      last_r <= 1'b0;
      abuf_r <= abytes;
      io_r   <= abytes[7:0];
      acyc_r <= nbi_pkg::CYC_ZERO;
    end else if (take_req) begin
      op_r   <= req_op;
      last_r <= req_last;
      io_r   <= req_byte;
    end else if (st_r == ST_ADDR_HIGH && tim_done && !cyc_done) begin
      acyc_r <= acyc_r + 3'h1;
      abuf_r <= {8'h00, abuf_r[39:8]};
      io_r   <= abuf_r[15:8];
    end
  end

  // Kind of the cycle about to start, decoded one edge ahead of the pins
  wire [1:0] nxt_op   = take_addr ? nbi_pkg::OP_ADDR : (take_req ? req_op : op_r);
  wire       nxt_rd   = (nxt_op == nbi_pkg::OP_DOUT);
  wire       nxt_byte = (st_nxt == ST_LOW) || (st_nxt == ST_HIGH);
  wire       nxt_addr = (st_nxt == ST_ADDR_LOW) || (st_nxt == ST_ADDR_HIGH);
  wire       nxt_cmd  = nxt_byte && (nxt_op == nbi_pkg::OP_CMD);
  wire       nxt_ale  = nxt_addr || (nxt_byte && nxt_op == nbi_pkg::OP_ADDR);

  // Pin drive: strobes and latch enables
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ce_n_r <= 1'b1;   // R1
      cle_r  <= 1'b0;
      ale_r  <= 1'b0;
      we_n_r <= 1'b1;
      re_n_r <= 1'b1;
      oe_n_r <= 1'b1;
    end else begin
      if (st_nxt == ST_LOW || st_nxt == ST_ADDR_LOW) begin
        ce_n_r <= 1'b0; // R2
      end else if (st_nxt == ST_IDLE && st_r != ST_IDLE && last_r) begin
        ce_n_r <= 1'b1; // R1
      end
      // Only one latch enable at a time; data cycles leave both low
      cle_r  <= nxt_cmd; // R4 R20 R22
      ale_r  <= nxt_ale; // R5 R20 R22
      we_n_r <= !((st_nxt == ST_LOW && !nxt_rd) || st_nxt == ST_ADDR_LOW); // R3
      re_n_r <= !(st_nxt == ST_LOW && nxt_rd); // R6
      oe_n_r <= (st_nxt == ST_IDLE) || nxt_rd; // R11
    end
  end

  // Column tracking mirrors device auto-increment
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      col_r  <= '0;
      row_r  <= '0;
      rb_s_r <= 1'b0;
    end else begin
      rb_s_r <= rb_in; // R9 R10
      if (take_addr) begin
        col_r <= addr_col;
        row_r <= addr_row;
      end else if (st_r == ST_HIGH && tim_done && (op_r == nbi_pkg::OP_DOUT ||
                   op_r == nbi_pkg::OP_DIN)) begin
        col_r <= col_r + nbi_pkg::COL_ONE; // R7 R19
      end
    end
  end

  // Read bytes wait here until the user takes them
  nbi_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_valid  (push_v),
    .in_ready  (fifo_in_ready),
    .in_data   (io_in),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );

  // Write protect pin is the inverse of the enable input; register-driven
  logic wp_n_r, busy_r, idle_r, rq_r;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wp_n_r <= 1'b0; // R8
      busy_r <= 1'b0;
      idle_r <= 1'b1;
      rq_r   <= 1'b0;
    end else begin
      wp_n_r <= !wp_enable; // R8
      busy_r <= (st_nxt != ST_IDLE);
      idle_r <= (st_nxt == ST_IDLE);
      // Ready only after a full idle edge
      rq_r   <= (st_nxt == ST_IDLE) && !take_req && !take_addr;
    end
  end

  assign req_ready = rq_r;
  assign busy      = busy_r;
  assign idle      = idle_r;
  assign dev_ready = rb_s_r;
  assign col_track = col_r;
  assign plane_sel = row_r[nbi_pkg::PLANE_BIT]; // R15
  assign page_sel  = row_r[nbi_pkg::PAGE_BITS-1:0]; // R21
  assign block_sel = row_r[nbi_pkg::ROW_W-1:nbi_pkg::PAGE_BITS]; // R17 R18 R21
  assign wp_n      = wp_n_r;
  assign ce_n      = ce_n_r;
  assign cle       = cle_r;
  assign ale       = ale_r;
  assign we_n      = we_n_r;
  assign re_n      = re_n_r;
  assign io_out    = io_r;
  assign io_oe_n   = oe_n_r;
endmodule // nbi_host

// ---- nbi_host_chk.sv ----
// Assertions on the host flash bus pins
`timescale 1ns/1ps
module nbi_host_chk (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst_n,
  // Requests
  input wire logic       req_valid,
  input wire logic       addr_valid,
  input wire logic [1:0] req_op,
  input wire logic       idle,
  input wire logic       wp_enable,
  // Flash pins
  input wire logic       ce_n,
  input wire logic       cle,
  input wire logic       ale,
  input wire logic       we_n,
  input wire logic       re_n,
  input wire logic       wp_n,
  input wire logic       io_oe_n
);
  wire take_w = idle && req_valid && !addr_valid;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence we_pulse;
    !we_n [*2] ##1 we_n;
  endsequence
  chk_one_latch: assert property (!(cle && ale))
    else $error("both latches high");
  chk_cmd_cycle: assert property (take_w && req_op == nbi_pkg::OP_CMD |=>
    we_pulse and (cle && !ale && !ce_n) [*3]) else $error("bad command cycle");
  chk_addr_cycle: assert property (take_w && req_op == nbi_pkg::OP_ADDR |=>
    we_pulse and (ale && !cle && !io_oe_n) [*3]) else $error("bad address cycle");
  chk_din_cycle: assert property (take_w && req_op == nbi_pkg::OP_DIN |=>
    !cle && !ale && !io_oe_n ##0 we_pulse) else $error("bad data write");
  chk_dout_cycle: assert property (take_w && req_op == nbi_pkg::OP_DOUT |=>
    !re_n && io_oe_n && !ce_n && !cle && !ale) else $error("bad data read");
  chk_we_sel: assert property ($rose(we_n) |-> !ce_n)
    else $error("write edge deselected");
  chk_read_bus: assert property (!re_n |-> we_n && io_oe_n)
    else $error("bus clash on read");
  chk_wp_follow: assert property (1'h1 |=> wp_n != $past(wp_enable))
    else $error("protect pin lags");
endmodule  // nbi_host_chk
bind nbi_host nbi_host_chk u_nbi_host_chk (.mclk, .rst_n, .req_valid, .addr_valid, .req_op,
  .idle, .wp_enable, .ce_n, .cle, .ale, .we_n, .re_n, .wp_n, .io_oe_n);

// ---- nbi_nand_model.sv ----
// Behavioural flash device answering the host bus
`timescale 1ns/1ps
module nbi_nand_model #(parameter int BUSY_NS = 300) (
  // Strobes
  input  wire logic       ce_n,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       re_n,
  input  wire logic       wp_n,
  // Bus and status
  input  wire logic [7:0] io_bus,
  output logic [7:0]      io_drv,
  output logic            rb_low
);
  logic [7:0]  cmd_r, addr_r [5], mem_r [64];
  logic [2:0]  acnt_r;
  logic [11:0] col_r;
  initial begin
    {acnt_r, col_r, rb_low} = '0;
    for (int i = 0; i < 64; i++) mem_r[i] = 8'(i) ^ 8'h5A;
  end
  // Released bus shows the inverse, never a valid byte
  assign io_drv = (!ce_n && !re_n) ? mem_r[col_r[5:0]] : ~mem_r[col_r[5:0]];
  always @(posedge re_n) if (!ce_n) col_r = col_r + 12'h001;
  always @(posedge we_n) if (!ce_n) begin
    if (cle) begin
      cmd_r = io_bus;
      acnt_r = 3'h0;
      if (io_bus == 8'h10 && wp_n) begin
        rb_low = 1'h1;
        rb_low <= #(BUSY_NS) 1'h0;
      end
    end else if (ale && acnt_r < 3'h5) begin
      addr_r[acnt_r] = io_bus;
      if (acnt_r == 3'h1) col_r = {io_bus[3:0], addr_r[0]};
      acnt_r = acnt_r + 3'h1;
    end else if (!ale && wp_n) begin
      mem_r[col_r[5:0]] = io_bus;
      col_r = col_r + 12'h001;
    end
  end
endmodule  // nbi_nand_model

// ---- testbench.sv ----
// Bench for the host controller against the device model
`timescale 1ns/1ps
module testbench;
  logic        mclk, rst_n, req_valid, req_last, addr_valid, rd_ready, wp_enable, rb_low;
  logic        req_ready, rd_valid, busy, idle, dev_ready, plane_sel;
  logic        ce_n, cle, ale, we_n, re_n, wp_n, io_oe_n;
  logic [1:0]  req_op;
  logic [5:0]  page_sel;
  logic [7:0]  req_byte, rd_data, io_out, io_drv, io_wire;
  logic [11:0] addr_col, col_track, block_sel;
  logic [17:0] addr_row;
  int          failures, checked;
  assign io_wire = io_oe_n ? io_drv : io_out;
  nbi_host u_nbi_host (.mclk, .rst_n, .req_valid, .req_ready, .req_op, .req_byte, .req_last,
    .addr_valid, .addr_col, .addr_row, .rd_valid, .rd_ready, .rd_data, .busy, .idle,
    .dev_ready, .col_track, .plane_sel, .page_sel, .block_sel, .wp_enable, .ce_n, .cle,
    .ale, .we_n, .re_n, .wp_n, .rb_in(!rb_low), .io_in(io_wire), .io_out, .io_oe_n);
  nbi_nand_model u_nbi_nand_model (.ce_n, .cle, .ale, .we_n, .re_n, .wp_n,
    .io_bus(io_wire), .io_drv, .rb_low);
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict;
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tick(ref int n);
    n++;
    if (n > 400) begin
      failures++;
      give_verdict();
    end else begin
      @(posedge mclk);
    end
  endtask
  task automatic await_ready;
    int n;
    n = 0;
    do tick(n); while (req_ready !== 1'h1);
  endtask
  task automatic issue(logic [1:0] op, logic [7:0] b, logic last);
    await_ready();
    req_op <= op;
    req_byte <= b;
    req_last <= last;
    req_valid <= 1'h1;
    @(posedge mclk);
    req_valid <= 1'h0;
  endtask
  task automatic load_addr(logic [11:0] c);
    await_ready();
    addr_col <= c;
    addr_row <= 18'h2_F3C1;
    addr_valid <= 1'h1;
    @(posedge mclk);
    addr_valid <= 1'h0;
    await_ready();
  endtask
  task automatic t_address;
    logic [39:0] bytes;
    bytes = 40'h02_F3C1_0A5C;
    load_addr(12'hA5C);
    for (int i = 0; i < 5; i++)
      check("addr byte", u_nbi_nand_model.addr_r[i], bytes[8*i+:8]);
    check("row split", {plane_sel, page_sel, block_sel}, {1'h1, 6'h01, 12'hBCF});
    issue(nbi_pkg::OP_ADDR, 8'h77, 1'h1);
    await_ready();
    check("extra addr", {u_nbi_nand_model.acnt_r, u_nbi_nand_model.mem_r[28]}, 11'h546);
  endtask
  task automatic t_write;
    int n;
    n = 0;
    issue(nbi_pkg::OP_CMD, 8'h80, 1'h0);
    load_addr(12'h003);
    for (int i = 0; i < 3; i++)
      issue(nbi_pkg::OP_DIN, 8'(8'hC1 + i), i == 2);
    await_ready();
    check("command", u_nbi_nand_model.cmd_r, 8'h80);
    for (int i = 3; i < 6; i++)
      check("written", u_nbi_nand_model.mem_r[i], 8'(8'hBE + i));
    check("column", col_track, 12'h006);
    check("deselect", ce_n, 1'h1);
    issue(nbi_pkg::OP_CMD, 8'h10, 1'h1);
    do tick(n); while (dev_ready !== 1'h0);
    do tick(n); while (dev_ready !== 1'h1);
  endtask
  task automatic t_protect;
    wp_enable <= 1'h1;
    issue(nbi_pkg::OP_DIN, 8'hEE, 1'h1);
    await_ready();
    check("protect", {wp_n, u_nbi_nand_model.mem_r[6]}, 9'h05C);
    wp_enable <= 1'h0;
  endtask
  task automatic t_read;
    int n, k;
    n = 0;
    k = 0;
    issue(nbi_pkg::OP_CMD, 8'h00, 1'h0);
    load_addr(12'h000);
    for (int i = 0; i < 17; i++)
      issue(nbi_pkg::OP_DOUT, 8'h00, i == 16);
    repeat (20) @(posedge mclk);
    check("full stall", {rd_valid, busy}, 2'h3);
    rd_ready <= 1'h1;
    while (k < 17) begin
      tick(n);
      if (rd_valid === 1'h1 && rd_ready === 1'h1) begin
        check("read", rd_data, (k > 2 && k < 6) ? 8'(8'hBE + k) : 8'(k) ^ 8'h5A);
        k++;
      end
    end
  endtask
  initial begin
    {rst_n, req_valid, req_last, addr_valid, rd_ready, wp_enable} = '0;
    {req_op, req_byte, addr_col, addr_row} = '0;
    failures = 0;
    checked = 0;
    repeat (12) @(posedge mclk);
    check("reset pins", {ce_n, cle, ale, we_n, re_n, wp_n, io_oe_n}, 7'h4D);
    rst_n <= 1'h1;
    t_address();
    t_write();
    t_protect();
    t_read();
    give_verdict();
  end
endmodule  // testbench
